// *** hp_slot_tracker.sv ***
// slot control command tracker for a hot-plug root port
// What this block does
// - tracking is built only for root ports numbered zero to ten, with or without hot-plug capability.
// - the command-completed flag, status bit four, is set only after the new command reaches the expander.
// - a new command is seen when power control, power indicator, attention indicator or interlock changes.
// - a slot control write that changes none of those four fields never sets command-completed.
// - a port without hot-plug capability never issues a command on a slot control write.
`timescale 1ns/10ps
`default_nettype none
module hp_slot_tracker #(
  parameter int unsigned PORT_NUM         = 0,
  parameter bit          HOTPLUG_CAPABLE  = 1'b1
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     cfg_wr_i,
  input  wire logic                     cfg_rd_i,
  input  wire logic [hp_pkg::CFG_AW-1:0] cfg_addr_i,
  input  wire logic [hp_pkg::REG_W-1:0]  cfg_wdata_i,
  output logic      [hp_pkg::REG_W-1:0]  cfg_rdata_o,
  output logic                          exp_valid_o,
  output logic      [hp_pkg::CMD_W-1:0]  exp_cmd_o,
  input  wire logic                     exp_done_i
);
  import hp_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (PORT_NUM > MAX_PORT) begin : g_bad_port
    $error("port number out of range");
  end

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic [REG_W-1:0] ctrl_q;
  logic [REG_W-1:0] rdata_q;
  logic             done_q, done_d;

  wire hit_ctrl   = (cfg_addr_i == SLOT_CONTROL_OFF);
  wire hit_status = (cfg_addr_i == SLOT_STATUS_OFF);
  wire wr_ctrl    = cfg_wr_i && hit_ctrl;
  wire wr_status  = cfg_wr_i && hit_status;

  wire [CMD_W-1:0] old_fields = ctrl_q[CMD_MSB:CMD_LSB];
  wire [CMD_W-1:0] new_fields = cfg_wdata_i[CMD_MSB:CMD_LSB];
  // compare covers interlock, power control, power and attention indicators
  wire             fields_changed = (old_fields != new_fields);
  // incapable ports keep the register but never launch a command
  wire             launch = wr_ctrl && fields_changed && HOTPLUG_CAPABLE;

  wire [REG_W-1:0] status_view = STATUS_RESET | (REG_W'(done_q) << CMD_DONE_BIT);
  wire [REG_W-1:0] rdata_d = hit_ctrl   ? ctrl_q :
                             hit_status ? status_view : '0;

  // ----------------------------------------
  // command delivery
  // ----------------------------------------
  hp_cmd_if cmd_bus ();

  assign cmd_bus.new_cmd    = launch;
  assign cmd_bus.cmd_fields = new_fields;

  hp_cmd_seq u_seq (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .cmd         (cmd_bus.seq),
    .exp_valid_o (exp_valid_o),
    .exp_cmd_o   (exp_cmd_o),
    .exp_done_i  (exp_done_i)
  );

  // ----------------------------------------
  // status flag: write one clears, a completion in the same cycle wins
  // ----------------------------------------
  wire clr_done = wr_status && cfg_wdata_i[CMD_DONE_BIT];

  always_comb begin
    done_d = done_q;
    if (clr_done) done_d = 1'b0;
    if (cmd_bus.cmd_complete) done_d = 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q  <= CTRL_RESET;
      done_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= cfg_wdata_i;
      done_q <= done_d;
      if (cfg_rd_i) rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata_o = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_done_after_deliver: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(done_q)
    |-> $past(exp_valid_o, 1) && $past(exp_done_i, 1))
    else $error("command-completed set without delivery");

  a_change_launches: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wr_ctrl && HOTPLUG_CAPABLE && (cfg_wdata_i[CMD_MSB:CMD_LSB] != ctrl_q[CMD_MSB:CMD_LSB]))
    |=> exp_valid_o && exp_cmd_o == $past(cfg_wdata_i[CMD_MSB:CMD_LSB]))
    else $error("changed field did not start a command");

  a_same_no_cmd: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!exp_valid_o && wr_ctrl && (cfg_wdata_i[CMD_MSB:CMD_LSB] == ctrl_q[CMD_MSB:CMD_LSB]))
    |=> !exp_valid_o)
    else $error("unchanged write started a command");

  a_no_hotplug_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !HOTPLUG_CAPABLE
    |-> !exp_valid_o && !done_q)
    else $error("incapable port issued a command");

  a_ctrl_stored: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_ctrl
    |=> ctrl_q == $past(cfg_wdata_i))
    else $error("slot control write not stored");

  a_ctrl_readback: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cfg_rd_i && hit_ctrl)
    |=> cfg_rdata_o == $past(ctrl_q))
    else $error("slot control read mismatch");

  // ----------------------------------------
  // status flag checks
  // ----------------------------------------
  a_done_set_wins: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cmd_bus.cmd_complete
    |=> done_q)
    else $error("completion did not set command-completed");

  a_done_cleared: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (clr_done && !cmd_bus.cmd_complete)
    |=> !done_q)
    else $error("write one did not clear command-completed");

  a_done_holds: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (done_q && !clr_done)
    |=> done_q)
    else $error("command-completed dropped without a clear");

  a_done_no_event: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!done_q && !cmd_bus.cmd_complete)
    |=> !done_q)
    else $error("command-completed set without a completion");

  // the ack of a replaced command must not count, or software would see a stale completion
  a_ack_replaced: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (exp_done_i && launch && !done_q)
    |=> !done_q)
    else $error("ack of a replaced command set command-completed");

  // ----------------------------------------
  // delivery checks
  // ----------------------------------------
  a_valid_until_done: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (exp_valid_o && !exp_done_i)
    |=> exp_valid_o)
    else $error("command withdrawn before delivery");

  a_done_ends_cmd: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (exp_valid_o && exp_done_i && !launch)
    |=> !exp_valid_o)
    else $error("command still pending after delivery");

  a_cmd_stands: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (exp_valid_o && !launch)
    |=> exp_cmd_o == $past(exp_cmd_o))
    else $error("pending command changed without a new write");

  a_idle_no_start: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!exp_valid_o && !launch)
    |=> !exp_valid_o)
    else $error("command started without a changed write");

  a_cmd_matches_ctrl: assert property (@(posedge core_clk_i) disable iff (reset_i)
    exp_valid_o
    |-> exp_cmd_o == ctrl_q[CMD_MSB:CMD_LSB])
    else $error("pending command differs from stored fields");

  // ----------------------------------------
  // register checks
  // ----------------------------------------
  a_status_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cfg_rd_i && hit_status)
    |=> cfg_rdata_o == (REG_W'($past(done_q)) << CMD_DONE_BIT))
    else $error("slot status read mismatch");

  a_unmapped_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cfg_rd_i && !hit_ctrl && !hit_status)
    |=> cfg_rdata_o == '0)
    else $error("unmapped read returned data");

  a_rdata_holds: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !cfg_rd_i
    |=> cfg_rdata_o == $past(cfg_rdata_o))
    else $error("read data changed without a read");

  a_ctrl_keeps: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !wr_ctrl
    |=> ctrl_q == $past(ctrl_q))
    else $error("slot control changed without a write");
endmodule : hp_slot_tracker
`default_nettype wire

// *** hp_pkg.sv ***
// constants shared by the slot command tracker files
package hp_pkg;
  localparam int          CFG_AW           = 12;
  localparam int          REG_W            = 16;
  localparam int          CMD_W            = 6;
  localparam int          MAX_PORT         = 10;
  localparam logic [11:0] SLOT_CONTROL_OFF = 12'h0a8;
  localparam logic [11:0] SLOT_STATUS_OFF  = 12'h0aa;
  localparam int          CMD_DONE_BIT     = 4;
  localparam int          ATTN_IND_LSB     = 6;
  localparam int          PWR_IND_LSB      = 8;
  localparam int          PWR_CTRL_BIT     = 10;
  localparam int          INTERLOCK_BIT    = 11;
  localparam int          CMD_LSB          = 6;
  localparam int          CMD_MSB          = 11;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_state_t;
endpackage : hp_pkg

// *** hp_cmd_if.sv ***
// carrier between the tracker and its delivery sequencer
`timescale 1ns/10ps
`default_nettype none
interface hp_cmd_if;
  import hp_pkg::*;
  logic             new_cmd;
  logic [CMD_W-1:0] cmd_fields;
  logic             cmd_complete;
  modport tracker (output new_cmd, output cmd_fields, input cmd_complete);
  modport seq     (input new_cmd, input cmd_fields, output cmd_complete);
endinterface : hp_cmd_if
`default_nettype wire

// *** hp_cmd_seq.sv ***
// delivers one slot command to the pin expander and reports delivery
`timescale 1ns/10ps
`default_nettype none
module hp_cmd_seq (
  input  wire logic                core_clk_i,
  input  wire logic                reset_i,
  hp_cmd_if.seq                    cmd,
  output logic                     exp_valid_o,
  output logic [hp_pkg::CMD_W-1:0] exp_cmd_o,
  input  wire logic                exp_done_i
);
  import hp_pkg::*;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  seq_state_t       state_q, state_d;
  logic [CMD_W-1:0] data_q;
  wire              delivered;

  // a command arriving with the old delivery still counts as undelivered
  assign delivered        = (state_q == SEQ_BUSY) && exp_done_i && !cmd.new_cmd;
  assign cmd.cmd_complete = delivered;
  assign exp_valid_o      = (state_q == SEQ_BUSY);
  assign exp_cmd_o        = data_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SEQ_IDLE: if (cmd.new_cmd) state_d = SEQ_BUSY;
      SEQ_BUSY: if (delivered) state_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= SEQ_IDLE;
      data_q  <= '0;
    end else begin
      state_q <= state_d;
      if (cmd.new_cmd) data_q <= cmd.cmd_fields;
    end
  end

  a_seq_done_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cmd.cmd_complete
    |=> !exp_valid_o)
    else $error("expander still busy after completion");
endmodule : hp_cmd_seq
`default_nettype wire

// *** hp_exp_model.sv ***
// pin expander stand-in: acknowledges each command lat_i + 1 cycles after valid rises
`timescale 1ns/10ps
`default_nettype none
module hp_exp_model (
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     exp_valid_i,
  input  wire logic [hp_pkg::CMD_W-1:0] exp_cmd_i,
  input  wire logic [3:0]               lat_i,
  output logic                          exp_done_o,
  output logic      [hp_pkg::CMD_W-1:0] pins_o
);
  import hp_pkg::*;
  logic [3:0] cnt_q;
  // done is a single-cycle pulse, never held, so a slack device cannot pass
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !exp_valid_i || exp_done_o) begin
      cnt_q      <= 4'h0;
      exp_done_o <= 1'b0;
    end else begin
      cnt_q      <= cnt_q + 4'h1;
      exp_done_o <= (cnt_q == lat_i);
    end
  end
  always_ff @(posedge core_clk_i) if (exp_done_o) pins_o <= exp_cmd_i;
endmodule : hp_exp_model
`default_nettype wire

// *** hp_slot_tracker_tb_top.sv ***
// self-checking bench for the slot command tracker
`timescale 1ns/10ps
`default_nettype none
module hp_slot_tracker_tb_top;
  import hp_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [CFG_AW-1:0] addr = 12'h000;
  logic [REG_W-1:0]  wdata = 16'h0000;
  logic [REG_W-1:0]  rdata, rdata_n, got;
  logic [REG_W-1:0]  ctrl = 16'h0000;
  logic              valid, valid_n, done;
  logic [CMD_W-1:0]  cmd, pins;
  logic [3:0]        lat = 4'h1;
  int                miscompares = 0;
  int                checked = 0;
  always #5 clk = ~clk;
  hp_slot_tracker #(.PORT_NUM(MAX_PORT)) u_dut (.core_clk_i(clk), .reset_i(rst),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .exp_valid_o(valid), .exp_cmd_o(cmd), .exp_done_i(done));
  hp_slot_tracker #(.HOTPLUG_CAPABLE(1'b0)) u_plain (.core_clk_i(clk), .reset_i(rst),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata_n), .exp_valid_o(valid_n), .exp_cmd_o(), .exp_done_i(1'b0));
  hp_exp_model u_exp (.core_clk_i(clk), .reset_i(rst), .exp_valid_i(valid),
    .exp_cmd_i(cmd), .lat_i(lat), .exp_done_o(done), .pins_o(pins));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
    rd = 1'b0;
    got = rdata;
  endtask : acc
  // software side: read first, wait for completion only on a real change
  task automatic sw_write(input logic [15:0] d);
    logic chg;
    acc(1'b0, SLOT_CONTROL_OFF, 16'h0000);
    chg = |((got ^ d) & 16'h0fc0);
    acc(1'b1, SLOT_CONTROL_OFF, d);
    chk({15'h0, valid}, {15'h0, chg});
    chk({15'h0, valid_n}, 16'h0000);
    chk({10'h0, cmd}, {10'h0, d[11:6]});
    if (chg) acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    if (chg) chk(got, 16'h0000);
    repeat (40) if (valid !== 1'b0) #10;
    chk({15'h0, valid}, 16'h0000);
    acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    chk(got, chg ? 16'h0010 : 16'h0000);
    chk(rdata_n, 16'h0000);
    if (chg) chk({10'h0, pins}, {10'h0, d[11:6]});
    acc(1'b1, SLOT_STATUS_OFF, 16'h0010);
    acc(1'b0, SLOT_CONTROL_OFF, 16'h0000);
    chk(got, d);
    chk(rdata_n, d);
    ctrl = d;
  endtask : sw_write
  task automatic t_reset;
    acc(1'b0, SLOT_CONTROL_OFF, 16'h0000);
    chk(got, CTRL_RESET);
    acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    chk(got, STATUS_RESET);
    acc(1'b0, 12'h0ac, 16'h0000);
    chk(got, 16'h0000);
  endtask : t_reset
  // each controlled field alone, with prompt and slow delivery
  task automatic t_fields;
    logic [15:0] m [4] = '{16'h0040, 16'h0100, 16'h0400, 16'h0800};
    for (int i = 0; i < 4; i++) begin
      lat = 4'(1 + 4 * i);
      sw_write(ctrl ^ m[i]);
    end
    sw_write(16'h0000);
  endtask : t_fields
  task automatic t_no_change;
    sw_write(ctrl ^ 16'hf03f);
    sw_write(ctrl);
  endtask : t_no_change
  // a second changed write while the first is pending replaces it
  task automatic t_busy;
    logic [15:0] a;
    logic [15:0] b;
    a = ctrl ^ 16'h0040;
    b = a ^ 16'h0100;
    lat = 4'h6;
    acc(1'b1, SLOT_CONTROL_OFF, a);
    acc(1'b1, SLOT_CONTROL_OFF, b);
    chk({15'h0, valid}, 16'h0001);
    chk({10'h0, cmd}, {10'h0, b[11:6]});
    acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    chk(got, 16'h0000);
    repeat (40) if (valid !== 1'b0) #10;
    chk({15'h0, valid}, 16'h0000);
    chk({10'h0, pins}, {10'h0, b[11:6]});
    acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    chk(got, 16'h0010);
    acc(1'b1, SLOT_STATUS_OFF, 16'h0010);
    ctrl = b;
  endtask : t_busy
  // completion meets a clear, then an ack meets a new changed write
  task automatic t_race;
    logic [15:0] a;
    logic [15:0] b;
    a = ctrl ^ 16'h0400;
    b = a ^ 16'h0800;
    lat = 4'h0;
    acc(1'b1, SLOT_CONTROL_OFF, a);
    acc(1'b1, SLOT_STATUS_OFF, 16'h0010);
    acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    chk(got, 16'h0010);
    acc(1'b1, SLOT_STATUS_OFF, 16'h0010);
    acc(1'b1, SLOT_CONTROL_OFF, b);
    acc(1'b1, SLOT_CONTROL_OFF, a);
    chk({15'h0, valid}, 16'h0001);
    acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    chk(got, 16'h0000);
    repeat (40) if (valid !== 1'b0) #10;
    chk({15'h0, valid}, 16'h0000);
    acc(1'b0, SLOT_STATUS_OFF, 16'h0000);
    chk(got, 16'h0010);
    chk({10'h0, pins}, {10'h0, a[11:6]});
    acc(1'b1, SLOT_STATUS_OFF, 16'h0010);
    ctrl = a;
  endtask : t_race
  task automatic results;
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_fields();
    t_no_change();
    t_busy();
    t_race();
    results();
  end
endmodule : hp_slot_tracker_tb_top
`default_nettype wire
